// ==== dv/mmt_pin_model.sv ====
// Purpose: External source on the shared timer pin.
// Assumes: Square wave of half period half while run is high.
// Notes:   Idles low; the device's drive wins while its enable is high.
`timescale 1ns/10ps
module mmt_pin_model (
   // Clock
   input wire logic clock,
   // Control from the bench
   input wire logic run,
   input wire logic [3:0] half,
   // Device side of the pin
   input wire logic pinOut,
   input wire logic pinOe,
   output logic pinIn
);
   logic level = 1'h0;
   logic [3:0] cnt = 4'h0;
   // Toggle every half cycles while running
   always_ff @(posedge clock) begin
      if (!run) begin
         level <= 1'h0;
         cnt <= 4'h0;
      end else if (cnt == half - 4'h1) begin
         level <= !level;
         cnt <= 4'h0;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
   // Wire level seen by the device
   assign pinIn = pinOe ? pinOut : level;
endmodule // mmt_pin_model

// ==== dv/mmt_timer_properties.sv ====
// Purpose: Port-level checks of the timer channel.
// Assumes: One clock, synchronous reset.
// Notes:   CTRL and MASK are shadowed from taken bus writes.
`timescale 1ns/10ps
module mmt_timer_properties (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clockEn,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   // Pin and interrupt
   input wire logic timerPinOut,
   input wire logic timerPinOe,
   input wire logic irq
);
   mmt_pkg::mmt_ctrl_s ctrl;
   mmt_pkg::mmt_ctrl_s wrCtrl;
   logic mask;
   logic take;
   logic ctrlWr;
   logic stopRun;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Decode of taken requests; mode[2:1] 01 means one-shot or PWM
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && clockEn;
   assign ctrlWr = take && wb_we_i && wb_adr_i[7:2] == mmt_pkg::REG_CTRL[7:2] && wb_sel_i[0];
   assign wrCtrl = mmt_pkg::mmt_ctrl_s'(wb_dat_i[6:0]);
   assign stopRun = ctrlWr && ctrl.start && !wrCtrl.start && wrCtrl.mode == ctrl.mode;
   // Shadow registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ctrl <= mmt_pkg::mmt_ctrl_s'(mmt_pkg::CTRL_RST);
         mask <= 1'h0;
      end else begin
         if (ctrlWr) begin
            ctrl <= wrCtrl;
         end
         if (take && wb_we_i && wb_adr_i[7:2] == mmt_pkg::REG_MASK[7:2] && wb_sel_i[0]) begin
            mask <= wb_dat_i[0];
         end
      end
   end
   // Pin falls, then the request shows on irq
   sequence fallThenReq;
      !timerPinOut ##1 irq;
   endsequence
   chk_stop_high: assert property (
      stopRun && ctrl.mode[2:1] == 2'h1 && timerPinOut && mask |=> fallThenReq)
      else $error("stop while high did not drop pin and request");
   chk_stop_low: assert property (
      stopRun && ctrl.mode == mmt_pkg::MODE_PWM && !timerPinOut |=> !timerPinOut [*3])
      else $error("pwm pin moved after stop while low");
   chk_mode_req: assert property (
      ctrlWr && ctrl.mode[2:1] == 2'h0 && wrCtrl.mode[2:1] == 2'h1 && mask |=> ##1 irq)
      else $error("mode change raised no request");
   chk_meas_req: assert property (
      ctrlWr && ctrl.start && wrCtrl.start && ctrl.mode == mmt_pkg::MODE_MEASURE
      && wrCtrl.mode == ctrl.mode && wrCtrl.measWidth != ctrl.measWidth && mask |=> ##1 irq)
      else $error("measurement select change raised no request");
   chk_pin_enable: assert property (
      $past(ctrl.mode) == ctrl.mode |-> timerPinOe == (ctrl.mode[2:1] == 2'h1))
      else $error("pin enable does not follow mode");
   // Masked request keeps irq low
   chk_irq_mask: assert property (!$past(mask) |-> !irq)
      else $error("irq high while masked");
   // Answer one cycle after a taken request
   chk_ack_next: assert property (take |=> wb_ack_o)
      else $error("ack missing after taken request");
   // Ack is a single-cycle pulse
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
endmodule // mmt_timer_properties

bind mmt_timer mmt_timer_properties chk (
   .clock(clock), .sys_rst(sys_rst), .clockEn(clockEn),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .timerPinOut(timerPinOut), .timerPinOe(timerPinOe), .irq(irq));

// ==== dv/tb_top.sv ====
// Purpose: Self-checking bench for the timer channel.
// Assumes: Wishbone classic master, one access every three cycles.
// Notes:   Mask is set early so requests show on irq.
`timescale 1ns/10ps
module tb_top;
   logic clock = 1'h0;
   logic sys_rst = 1'h1;
   logic clockEn = 1'h1;
   logic wb_cyc_i = 1'h0;
   logic wb_stb_i = 1'h0;
   logic wb_we_i = 1'h0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic pinIn;
   logic timerPinOut;
   logic timerPinOe;
   logic irq;
   logic pinRun = 1'h0;
   logic [31:0] rd;
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;
   always #2.5 clock = ~clock;
   mmt_timer dut (
      .clock(clock), .sys_rst(sys_rst), .clockEn(clockEn),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .timerPinIn(pinIn), .timerPinOut(timerPinOut), .timerPinOe(timerPinOe), .irq(irq));
   mmt_pin_model pins (.clock(clock), .run(pinRun), .half(4'h5), .pinOut(timerPinOut),
      .pinOe(timerPinOe), .pinIn(pinIn));
   // Verdict and end of run
   task automatic stop_test();
      $display("tests %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Compare and count
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One classic cycle; read data lands in rd
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      do begin
         @(posedge clock);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 20);
      check("ack", {31'h0, wb_ack_o}, 32'h1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'h1, a, d);
   endtask
   task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
      bus(1'h0, a, 32'h0);
      check(name, rd, exp);
   endtask
   // Bounded wait for a level on a line
   task automatic wait_for(input logic v, input logic onPin);
      int n;
      n = 0;
      while ((onPin ? timerPinOut : pinIn) !== v && n < 100) begin
         @(posedge clock);
         n++;
      end
      check("line level", {31'h0, onPin ? timerPinOut : pinIn}, {31'h0, v});
   endtask
   function automatic logic [31:0] ctl(input logic [2:0] m, input logic s, input logic [2:0] f);
      return {25'h0, f, s, m};
   endfunction
   // Reset values, unmapped place, mask
   task automatic t_reset();
      for (int a = 0; a < 28; a += 4) rdc("reset value", 8'(a), 32'h0);
      wr(8'h18, 32'hFFFF_FFFF);
      rdc("unmapped", 8'h18, 32'h0);
      check("pin enable", {31'h0, timerPinOe}, 32'h0);
      wr(mmt_pkg::REG_MASK, 32'h1);
      rdc("mask", mmt_pkg::REG_MASK, 32'h1);
   endtask
   // Every listed mode change sets the request
   task automatic t_modes();
      for (int f = 0; f < 2; f++) begin
         for (int t = 2; t < 4; t++) begin
            wr(mmt_pkg::REG_CTRL, ctl(3'(f), 1'h0, 3'h0));
            wr(mmt_pkg::REG_STATUS, 32'h1);
            wr(mmt_pkg::REG_CTRL, ctl(3'(t), 1'h0, 3'h0));
            rdc("mode request", mmt_pkg::REG_STATUS, 32'h1);
            check("irq", {31'h0, irq}, 32'h1);
            wr(mmt_pkg::REG_STATUS, 32'h1);
         end
      end
   endtask
   // Timer mode: live reads and the reload instant
   task automatic t_timer();
      logic saw;
      logic bad;
      saw = 1'h0;
      bad = 1'h0;
      wr(mmt_pkg::REG_CTRL, ctl(mmt_pkg::MODE_TIMER, 1'h0, 3'h0));
      wr(mmt_pkg::REG_COUNT, 32'h0001_0003);
      rdc("halted count", mmt_pkg::REG_COUNT, 32'h3);
      wr(mmt_pkg::REG_CTRL, ctl(mmt_pkg::MODE_TIMER, 1'h1, 3'h0));
      repeat (10) begin
         bus(1'h0, mmt_pkg::REG_COUNT, 32'h0);
         if (rd === 32'hFFFF) saw = 1'h1;
         else if (rd > 32'h3) bad = 1'h1;
      end
      check("live count", {31'h0, bad}, 32'h0);
      check("reload instant", {31'h0, saw}, 32'h1);
      wr(mmt_pkg::REG_CTRL, ctl(mmt_pkg::MODE_TIMER, 1'h0, 3'h0));
      check("irq", {31'h0, irq}, 32'h1);
      wr(mmt_pkg::REG_STATUS, 32'h1);
      rdc("cleared", mmt_pkg::REG_STATUS, 32'h0);
      check("irq", {31'h0, irq}, 32'h0);
   endtask
   // Event mode, down or up, then a free-run restart
   task automatic t_event(input logic up);
      logic saw;
      saw = 1'h0;
      wr(mmt_pkg::REG_COUNT, up ? 32'hFFFE : 32'h1);
      wr(mmt_pkg::REG_CTRL, ctl(mmt_pkg::MODE_EVENT, 1'h1, {1'h0, up, 1'h0}));
      pinRun <= 1'h1;
      repeat (24) begin
         bus(1'h0, mmt_pkg::REG_COUNT, 32'h0);
         if (rd === (up ? 32'h0 : 32'hFFFF)) saw = 1'h1;
      end
      pinRun <= 1'h0;
      check("event wrap", {31'h0, saw}, 32'h1);
      wr(mmt_pkg::REG_CTRL, ctl(mmt_pkg::MODE_EVENT, 1'h0, 3'h4));
      wr(mmt_pkg::REG_COUNT, 32'h5);
      wr(mmt_pkg::REG_CTRL, ctl(mmt_pkg::MODE_EVENT, 1'h1, 3'h4));
      rdc("free run count", mmt_pkg::REG_COUNT, 32'h5);
      wr(mmt_pkg::REG_CTRL, ctl(mmt_pkg::MODE_EVENT, 1'h0, 3'h4));
   endtask
   // One-shot stopped by software
   task automatic t_oneshot();
      wr(mmt_pkg::REG_STATUS, 32'h1);
      wr(mmt_pkg::REG_COUNT, 32'h28);
      wr(mmt_pkg::REG_CTRL, ctl(mmt_pkg::MODE_ONESHOT, 1'h0, 3'h0));
      rdc("mode request", mmt_pkg::REG_STATUS, 32'h1);
      wr(mmt_pkg::REG_STATUS, 32'h1);
      wr(mmt_pkg::REG_CTRL, ctl(mmt_pkg::MODE_ONESHOT, 1'h1, 3'h0));
      check("pin high", {31'h0, timerPinOut}, 32'h1);
      wr(mmt_pkg::REG_CTRL, ctl(mmt_pkg::MODE_ONESHOT, 1'h0, 3'h0));
      check("pin low", {30'h0, timerPinOe, timerPinOut}, 32'h2);
      rdc("reloaded", mmt_pkg::REG_COUNT, 32'h28);
      rdc("stop request", mmt_pkg::REG_STATUS, 32'h1);
      wr(mmt_pkg::REG_STATUS, 32'h1);
   endtask
   // PWM stopped with output high or low
   task automatic t_pwm(input logic [31:0] duty, input logic high);
      wr(mmt_pkg::REG_COUNT, 32'h14);
      wr(mmt_pkg::REG_DUTY, duty);
      wr(mmt_pkg::REG_CTRL, ctl(mmt_pkg::MODE_PWM, 1'h0, 3'h0));
      wr(mmt_pkg::REG_STATUS, 32'h1);
      wr(mmt_pkg::REG_CTRL, ctl(mmt_pkg::MODE_PWM, 1'h1, 3'h0));
      wait_for(1'h1, 1'h1);
      if (!high) begin
         wait_for(1'h0, 1'h1);
         wr(mmt_pkg::REG_STATUS, 32'h1);
      end
      wr(mmt_pkg::REG_CTRL, ctl(mmt_pkg::MODE_PWM, 1'h0, 3'h0));
      check("pwm pin", {31'h0, timerPinOut}, 32'h0);
      rdc("pwm stop request", mmt_pkg::REG_STATUS, {31'h0, high});
      wr(mmt_pkg::REG_STATUS, 32'h1);
   endtask
   // Measurement: silent first edge, select change, width edges
   task automatic t_measure();
      wr(mmt_pkg::REG_CTRL, ctl(mmt_pkg::MODE_MEASURE, 1'h1, 3'h0));
      wr(mmt_pkg::REG_STATUS, 32'h1);
      pinRun <= 1'h1;
      wait_for(1'h1, 1'h0);
      repeat (3) @(posedge clock);
      rdc("first edge", mmt_pkg::REG_STATUS, 32'h0);
      wait_for(1'h0, 1'h0);
      wait_for(1'h1, 1'h0);
      pinRun <= 1'h0;
      repeat (3) @(posedge clock);
      rdc("second edge", mmt_pkg::REG_STATUS, 32'h1);
      wr(mmt_pkg::REG_STATUS, 32'h1);
      wr(mmt_pkg::REG_CTRL, ctl(mmt_pkg::MODE_MEASURE, 1'h1, 3'h1));
      rdc("select request", mmt_pkg::REG_STATUS, 32'h1);
      pinRun <= 1'h1;
      wait_for(1'h1, 1'h0);
      wr(mmt_pkg::REG_STATUS, 32'h1);
      wait_for(1'h0, 1'h0);
      repeat (3) @(posedge clock);
      rdc("width edge", mmt_pkg::REG_STATUS, 32'h1);
   endtask
   // Hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         stop_test();
      end
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge clock);
      sys_rst <= 1'h0;
      @(posedge clock);
      t_reset();
      t_modes();
      t_timer();
      t_event(1'h0);
      t_event(1'h1);
      t_oneshot();
      t_pwm(32'h12, 1'h1);
      t_pwm(32'h2, 1'h0);
      t_measure();
      stop_test();
   end
endmodule // tb_top

// ==== verilog/mmt_pkg.sv ====
// Purpose: Shared constants and types for the multi-mode timer channel.
// Assumes: One 32-bit classic Wishbone slave port, word-aligned registers.
// Notes:   Counter width is a module parameter; these are the default layouts.

package mmt_pkg;

   // ***************************************************************
   // Register map (byte addresses)
   // ***************************************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_COUNT = 8'h04;
   localparam logic [7:0] REG_RELOAD = 8'h08;
   localparam logic [7:0] REG_DUTY = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_MASK = 8'h14;

   // ***************************************************************
   // Widths and field positions
   // ***************************************************************
   localparam int CNT_W_DEF = 16;
   localparam int CTRL_W = 7;
   localparam int STAT_W = 1;
   localparam int STAT_REQ_BIT = 0;

   // ***************************************************************
   // Operating modes
   // ***************************************************************
   typedef enum logic [2:0] {
      MODE_TIMER   = 3'b000,
      MODE_EVENT   = 3'b001,
      MODE_ONESHOT = 3'b010,
      MODE_PWM     = 3'b011,
      MODE_MEASURE = 3'b100
   } mmt_mode_e;

   // Control register layout, bit 0 upward: mode, start, measWidth, countUp, freeRun
   typedef struct packed {
      logic freeRun;
      logic countUp;
      logic measWidth;
      logic start;
      mmt_mode_e mode;
   } mmt_ctrl_s;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
   localparam logic [STAT_W-1:0] STAT_RST = 1'h0;
   localparam logic [STAT_W-1:0] MASK_RST = 1'h0;

endpackage

// ==== verilog/mmt_timer.sv ====
// Purpose: One general-purpose timer channel with timer, event counter,
//          one-shot, PWM and pulse period/width measurement modes.
// Assumes: Pin input is synchronous to clock; software on classic Wishbone.
// Notes:   The same channel serves as primary, measurement and auxiliary timer.
//
// The register addresses and the Wishbone slave port are this design's own decisions.

`timescale 1ns/10ps

module mmt_timer #(
   parameter int CNT_W = mmt_pkg::CNT_W_DEF
) (
   // Clock, reset and freeze
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clockEn,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Timer pin, three-signal form
   input wire logic timerPinIn,
   output logic timerPinOut,
   output logic timerPinOe,
   // Interrupt
   output logic irq
);

   // ***************************************************************
   // Parameter check
   // ***************************************************************
   if (CNT_W < 2 || CNT_W > 32) begin : gBadWidth
      $error("mmt_timer: CNT_W must lie between 2 and 32");
   end

   // ***************************************************************
   // Helpers
   // ***************************************************************
   // Byte-lane merge of a write onto the old register contents
   function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
                                              input logic [31:0] newVal,
                                              input logic [3:0] sel);
      logic [31:0] res;
      res = oldVal;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = newVal[8*b +: 8];
         end
      end
      return res;
   endfunction

   // Zero-extend a counter-width value onto the data bus
   function automatic logic [31:0] widen(input logic [CNT_W-1:0] v);
      logic [31:0] res;
      res = '0;
      res[CNT_W-1:0] = v;
      return res;
   endfunction

   // ***************************************************************
   // State
   // ***************************************************************
   mmt_pkg::mmt_ctrl_s ctrl;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] reloadVal;
   logic [CNT_W-1:0] duty;
   logic [mmt_pkg::STAT_W-1:0] status;
   logic [mmt_pkg::STAT_W-1:0] mask;
   logic reloadPend, osRun, firstSeen, pinPrev, outLevel;

   // Combinational terms
   mmt_pkg::mmt_ctrl_s newCtrl;
   logic [31:0] ctrlWord, countWord, dutyWord, maskWord;
   logic busWr, busRd;
   logic wrCtrl, wrCount, wrDuty, wrStatus, wrMask;
   logic startRise, startClr, modeSpur, measFlip, isMeasure, pinRise, pinFall, activeEdge;
   logic upDir, tick, wrapNow, osEnd, osStop, measReq, pwmFall, setReq;
   logic [CNT_W-1:0] next_count;
   logic next_reloadPend, next_outLevel;

   // ***************************************************************
   // Bus decode
   // ***************************************************************
   // A request is acted on once, at the edge where the acknowledge rises
   assign busWr = clockEn & wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
   assign busRd = clockEn & wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
   assign wrCtrl = busWr & ({wb_adr_i[7:2], 2'b00} == mmt_pkg::REG_CTRL);
   assign wrCount = busWr & ({wb_adr_i[7:2], 2'b00} == mmt_pkg::REG_COUNT);
   assign wrDuty = busWr & ({wb_adr_i[7:2], 2'b00} == mmt_pkg::REG_DUTY);
   assign wrStatus = busWr & ({wb_adr_i[7:2], 2'b00} == mmt_pkg::REG_STATUS);
   assign wrMask = busWr & ({wb_adr_i[7:2], 2'b00} == mmt_pkg::REG_MASK);

   // Merged write words for the control, count, duty and mask registers
   assign ctrlWord = mergeBytes({25'h0000000, ctrl}, wb_dat_i, wb_sel_i);
   assign countWord = mergeBytes(widen(count), wb_dat_i, wb_sel_i);
   assign dutyWord = mergeBytes(widen(duty), wb_dat_i, wb_sel_i);
   assign maskWord = mergeBytes({31'h00000000, mask}, wb_dat_i, wb_sel_i);
   assign newCtrl = mmt_pkg::mmt_ctrl_s'(ctrlWord[mmt_pkg::CTRL_W-1:0]);

   // ***************************************************************
   // Event decode
   // ***************************************************************
   // Start flag edges caused by software
   assign startRise = wrCtrl & ~ctrl.start & newCtrl.start;
   assign startClr = wrCtrl & ctrl.start & ~newCtrl.start;
   assign isMeasure = (ctrl.mode == mmt_pkg::MODE_MEASURE);

   assign modeSpur = wrCtrl & (newCtrl.mode != ctrl.mode)
                     & ((newCtrl.mode == mmt_pkg::MODE_ONESHOT)
                        | (newCtrl.mode == mmt_pkg::MODE_PWM))
                     & ((ctrl.mode == mmt_pkg::MODE_TIMER)
                        | (ctrl.mode == mmt_pkg::MODE_EVENT));

   assign measFlip = wrCtrl & isMeasure & ctrl.start
                     & (newCtrl.measWidth != ctrl.measWidth);

   // Pin edges; width measurement uses both edges, period only rising
   assign pinRise = timerPinIn & ~pinPrev;
   assign pinFall = ~timerPinIn & pinPrev;
   assign activeEdge = isMeasure & ctrl.start & (ctrl.measWidth ? (pinRise | pinFall) : pinRise);

   // Count direction and count enable per mode
   assign upDir = isMeasure | ((ctrl.mode == mmt_pkg::MODE_EVENT) & ctrl.countUp);
   always_comb begin
      case (ctrl.mode)
         mmt_pkg::MODE_TIMER: tick = ctrl.start;
         mmt_pkg::MODE_EVENT: tick = ctrl.start & pinRise;
         mmt_pkg::MODE_ONESHOT: tick = osRun;
         mmt_pkg::MODE_PWM: tick = ctrl.start;
         mmt_pkg::MODE_MEASURE: tick = ctrl.start;
         default: tick = 1'b0;
      endcase
   end

   // Wrap past the end of the range marks a reload instant
   assign wrapNow = tick & ~reloadPend & ~isMeasure
                    & (upDir ? (&count) : (count == '0));

   // One-shot terminal count and software stop
   assign osEnd = (ctrl.mode == mmt_pkg::MODE_ONESHOT) & osRun & wrapNow;
   assign osStop = (ctrl.mode == mmt_pkg::MODE_ONESHOT) & osRun & startClr;

   assign measReq = activeEdge & firstSeen;

   // ***************************************************************
   // Counter next value
   // ***************************************************************
   // Priority: software load when halted, one-shot stop, reload, capture, count
   always_comb begin
      next_count = count;
      next_reloadPend = 1'b0;
      if (wrCount && !ctrl.start) begin
         next_count = countWord[CNT_W-1:0];
      end else if (osStop) begin
         next_count = reloadVal;
      end else if (reloadPend && !(ctrl.mode == mmt_pkg::MODE_EVENT && ctrl.freeRun)) begin
         next_count = reloadVal;
      end else if (activeEdge) begin
         next_count = '0;
      end else if (tick && !reloadPend) begin
         if (upDir) begin
            next_count = count + 1'b1;
         end else begin
            next_count = count - 1'b1;
         end
         next_reloadPend = wrapNow;
      end
   end

   // CNT_W-bit counter, sixteen bits by default
   // Counter and reload-pending flag
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         count <= '0;
         reloadPend <= 1'b0;
      end else if (clockEn) begin
         count <= next_count;
         reloadPend <= next_reloadPend;
      end
   end

   // ***************************************************************
   // Reload and duty registers
   // ***************************************************************
   // Count writes always reach the reload register; capture overrides in measurement
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reloadVal <= '0;
      end else if (clockEn) begin
         if (activeEdge) begin
            reloadVal <= count;
         end else if (wrCount) begin
            reloadVal <= countWord[CNT_W-1:0];
         end
      end
   end

   // PWM high time in counter ticks
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         duty <= '0;
      end else if (clockEn && wrDuty) begin
         duty <= dutyWord[CNT_W-1:0];
      end
   end

   // ***************************************************************
   // Control register and mode flags
   // ***************************************************************
   // Software control word
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ctrl <= mmt_pkg::mmt_ctrl_s'(mmt_pkg::CTRL_RST);
      end else if (clockEn && wrCtrl) begin
         ctrl <= newCtrl;
      end
   end

   // One-shot run flag: armed by a start write, ended by terminal count or stop
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         osRun <= 1'b0;
      end else if (clockEn) begin
         if (wrCtrl && newCtrl.mode != mmt_pkg::MODE_ONESHOT) begin
            osRun <= 1'b0;
         end else if (osEnd || osStop) begin
            osRun <= 1'b0;
         end else if (startRise && newCtrl.mode == mmt_pkg::MODE_ONESHOT) begin
            osRun <= 1'b1;
         end
      end
   end

   // Measurement first-edge tracking, cleared whenever counting is off
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         firstSeen <= 1'b0;
      end else if (clockEn) begin
         if (!ctrl.start || startRise) begin
            firstSeen <= 1'b0;
         end else if (activeEdge) begin
            firstSeen <= 1'b1;
         end
      end
   end

   // Pin history for edge detection
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pinPrev <= 1'b0;
      end else if (clockEn) begin
         pinPrev <= timerPinIn;
      end
   end

   // ***************************************************************
   // Output pin
   // ***************************************************************
   // Next pin level per mode
   always_comb begin
      next_outLevel = 1'b0;
      case (ctrl.mode)
         mmt_pkg::MODE_ONESHOT: begin
            if (osEnd || osStop) begin
               next_outLevel = 1'b0;
            end else if (startRise) begin
               next_outLevel = 1'b1;
            end else begin
               next_outLevel = outLevel;
            end
         end
         mmt_pkg::MODE_PWM: begin
            next_outLevel = ctrl.start & ~startClr & (next_count < duty);
         end
         default: next_outLevel = 1'b0;
      endcase
   end

   // Pin level and drive enable
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         outLevel <= 1'b0;
         timerPinOe <= 1'b0;
      end else if (clockEn) begin
         outLevel <= next_outLevel;
         timerPinOe <= (ctrl.mode == mmt_pkg::MODE_ONESHOT) | (ctrl.mode == mmt_pkg::MODE_PWM);
      end
   end
   assign timerPinOut = outLevel;

   // request only on a falling pulse
   assign pwmFall = (ctrl.mode == mmt_pkg::MODE_PWM) & outLevel & ~next_outLevel;

   // ***************************************************************
   // Interrupt status and mask
   // ***************************************************************
   // request on timer or event wrap, one-shot end or stop, PWM fall, measurement and mode change
   assign setReq = (wrapNow & ((ctrl.mode == mmt_pkg::MODE_TIMER)
                               | (ctrl.mode == mmt_pkg::MODE_EVENT)))
                   | osEnd | osStop | pwmFall | measReq | modeSpur | measFlip;

   // Sticky request; a new event wins over a same-cycle write-one clear
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         status <= mmt_pkg::STAT_RST;
      end else if (clockEn) begin
         status[mmt_pkg::STAT_REQ_BIT] <= setReq
            | (status[mmt_pkg::STAT_REQ_BIT]
               & ~(wrStatus & wb_sel_i[0] & wb_dat_i[mmt_pkg::STAT_REQ_BIT]));
      end
   end

   // Interrupt mask, one enables the request onto the line
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mask <= mmt_pkg::MASK_RST;
      end else if (clockEn && wrMask) begin
         mask <= maskWord[mmt_pkg::STAT_W-1:0];
      end
   end

   // Level interrupt from masked sticky bits
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else if (clockEn) begin
         irq <= |(status & mask);
      end
   end

   // ***************************************************************
   // Wishbone answer
   // ***************************************************************
   // One wait state; unmapped addresses answer zero and ignore writes
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else if (clockEn) begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         if (busRd) begin
            case ({wb_adr_i[7:2], 2'b00})
               mmt_pkg::REG_CTRL: wb_dat_o <= {25'h0000000, ctrl};
               mmt_pkg::REG_COUNT: wb_dat_o <= widen(count);
               mmt_pkg::REG_RELOAD: wb_dat_o <= widen(reloadVal);
               mmt_pkg::REG_DUTY: wb_dat_o <= widen(duty);
               mmt_pkg::REG_STATUS: wb_dat_o <= {31'h00000000, status};
               mmt_pkg::REG_MASK: wb_dat_o <= {31'h00000000, mask};
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

endmodule // mmt_timer
